//--- bench/dps_host_model.sv
// Partner model of the host side: frame clock and jump-condition pins.
// Assumes one frame request at a time, raised for one clock by the bench.
`default_nettype none
module dps_host_model (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [7:0] cond_in,
  output logic frame_clock = 1'b0,
  output logic [7:0] ext_jump_cond = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 0;
  ////////////////////////////////////////////////////////////////////////
  // Condition pins settle a cycle before the frame edge; frame clock
  // stands low between frames, as a gated source would
  always @(posedge aclk) begin
    if (fire) begin
      ext_jump_cond <= cond_in;
      hold <= 8;
    end else if (hold > 0) begin
      frame_clock <= 1'b1;
      hold <= hold - 1;
    end else begin
      frame_clock <= 1'b0;
    end
  end
endmodule : dps_host_model
`default_nettype wire

//--- bench/tb_dsp_program_sequencer.sv
// Self-checking bench for the program sequencer.
// Assumes the AXI4-Lite slave timing and command encoding of the package.
`default_nettype none
module tb_dsp_program_sequencer
  import dps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr, cond_in, lower_byte_store, ext_jump_cond;
  logic awvalid, wvalid, bready, arvalid, rready, fire, frame_clock;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  dps_flags_t alu_flags;
  logic [23:0] alu_result, internal_data_bus, dest_word, lit;
  logic [15:0] ext_data16, dest_upper;
  logic [8:0] program_counter;
  dps_issue_t issue;
  int fails = 0;
  int cmp_count = 0;
  // Program: flag jumps, condition jump, call, loop, literal, end
  logic [31:0] prog[14] = '{32'h02E00000, 32'h20000209, 32'h20000804,
    32'h80000000, 32'h30000006, 32'h10000007, 32'h10000007, 32'h4000000C,
    32'h6000200A, 32'h05000000, 32'h03800000, 32'h80000000, 32'h71000000,
    32'h50000000};
  int e1[] = '{1, 2, 4, 4, 5, 7, 7, 12, 12, 13, 8, 9, 10, 9, 10, 11};
  int e2[] = '{1, 2, 4, 4, 6, 6, 7, 7, 12, 12, 13, 8, 9, 10, 9, 10, 11};

  // Free-running system clock
  always #2.5 aclk = ~aclk;

  dps_sequencer u_dps_sequencer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frame_clock(frame_clock),
    .ext_jump_cond(ext_jump_cond), .alu_flags(alu_flags),
    .alu_result(alu_result), .ext_data16(ext_data16),
    .program_counter(program_counter),
    .internal_data_bus(internal_data_bus), .issue(issue),
    .dest_word(dest_word), .dest_upper(dest_upper),
    .lower_byte_store(lower_byte_store));

  dps_host_model u_dps_host_model (.aclk(aclk), .fire(fire),
    .cond_in(cond_in), .frame_clock(frame_clock),
    .ext_jump_cond(ext_jump_cond));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic stop_test;
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // A 16-bit source lands left-aligned with low byte zero
  function automatic logic [23:0] fill16(input logic [15:0] v);
    return {v, 8'h00};
  endfunction : fill16

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master: hold each channel until its own ready
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr

  ////////////////////////////////////////////////////////////////////////
  // One sample period: trace the counter, then watch the end stall
  task automatic run_frame(input logic [7:0] c, input int e[]);
    logic [8:0] pq[$];
    logic [23:0] bq[$];
    int i, hit;
    cond_in <= c;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (36) begin
      @(posedge aclk);
      #1;
      pq.push_back(program_counter);
      bq.push_back(internal_data_bus);
    end
    i = 0;
    hit = 0;
    // Skip the stall, then the idle zeros and word zero itself
    while (i < 36 && pq[i] !== 9'h000) i++;
    while (i < 36 && pq[i] === 9'h000) i++;
    foreach (e[k]) chk(32'(pq[i + k]), e[k]);
    foreach (bq[k]) if (bq[k] === fill16(ext_data16)) hit++;
    chk(32'(hit != 0), 32'h1);
    repeat (6) begin
      @(posedge aclk);
      #1;
      chk(32'(issue), 32'h0);
      chk(32'(internal_data_bus), 32'h0);
    end
    @(posedge aclk);
  endtask : run_frame

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, fire} = 6'h00;
    {awaddr, araddr, cond_in, wdata, wstrb} = 60'h0;
    void'($urandom(32'hE17777D7));
    alu_flags = 3'b100;
    alu_result = 24'($urandom);
    ext_data16 = 16'($urandom);
    lit = 24'($urandom);
    prog[12] = prog[12] | {8'h00, lit};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(32'(program_counter), 32'h0);
    chk(32'(internal_data_bus), 32'h0);
    @(posedge aclk);
    axr(REG_EXT_COND);
    chk(rd, 32'h0);
    axr(8'h18);
    chk(32'(resp), 32'(RESP_SLVERR));
    axw(REG_CTRL, 32'h0);
    axw(REG_PROGRAM_RAM_ADDR, 32'h0);
    foreach (prog[k]) axw(REG_PROGRAM_RAM_DATA, prog[k]);
    axw(REG_PROGRAM_RAM_ADDR, 32'hC);
    axr(REG_PROGRAM_RAM_DATA);
    chk(rd, prog[12]);
    axw(REG_EXT_COND, 32'h0F);
    axw(REG_CTRL, 32'h1);
    axw(REG_PROGRAM_RAM_DATA, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    repeat (6) @(posedge aclk);
    chk(32'(program_counter), 32'h0);
    run_frame(8'h30, e1);
    chk(32'(dest_word), 32'(lit));
    chk(32'(dest_upper), 32'(ext_data16));
    chk(32'(lower_byte_store), 32'(alu_result[7:0]));
    axr(REG_STATUS);
    chk(32'(rd[23:16]), 32'h30);
    alu_result <= 24'($urandom);
    ext_data16 <= 16'($urandom);
    @(posedge aclk);
    run_frame(8'h11, e2);
    axr(REG_STATUS);
    chk(32'(rd[23:16]), 32'h11);
    // First frame ran 14 words outside the three idle slots, no overrun
    axr(REG_STEPS);
    chk(rd, 32'h0000000E);
    // Second reset in the end stall
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk(32'(program_counter), 32'h0);
    chk(32'(internal_data_bus), 32'h0);
    stop_test;
  end

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule : tb_dsp_program_sequencer
`default_nettype wire

//--- hw/dps_pkg.sv
// Shared constants and types for the program sequencer block.
// Assumes one clock domain and an AXI4-Lite master for register access.
`default_nettype none
package dps_pkg;
  //////////////////////////////////////////////////////////////////////////
  // Widths and sizes
  localparam int PC_W = 9;
  localparam int DATA_W = 24;
  localparam int WORD_W = 32;
  localparam int COND_W = 8;
  localparam int LOOP_W = 5;
  localparam int PROGRAM_RAM_WORDS = 384;
  localparam int FRAME_STEPS = 574;
  localparam int STEP_W = 10;
  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EXT_COND = 8'h04;
  localparam logic [7:0] REG_PROGRAM_RAM_ADDR = 8'h08;
  localparam logic [7:0] REG_PROGRAM_RAM_DATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_STEPS = 8'h14;
  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 9'h000;
  localparam logic [COND_W-1:0] EXT_COND_RESET = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  //////////////////////////////////////////////////////////////////////////
  // Instruction word field positions
  localparam int OPC_LSB = 28;
  localparam int TGT_LSB = 0;
  localparam int CMASK_LSB = 9;
  localparam int LCNT_LSB = 12;
  localparam int SRC_LSB = 25;
  localparam int DST_LSB = 23;
  localparam int MUL_BIT = 22;
  localparam int ADD_BIT = 21;
  localparam int SUB_BIT = 20;
  localparam int LDST_LSB = 24;
  // Status field positions
  localparam int STAT_ST_LSB = 12;
  localparam int STAT_JC_LSB = 16;
  //////////////////////////////////////////////////////////////////////////
  // Commands, states, sources and destinations
  typedef enum logic [3:0] {
    DPS_OP_EXEC = 4'h0, DPS_OP_JMP = 4'h1, DPS_OP_JC = 4'h2,
    DPS_OP_JX = 4'h3, DPS_OP_CALL = 4'h4, DPS_OP_RET = 4'h5,
    DPS_OP_LOOP = 4'h6, DPS_OP_LD = 4'h7, DPS_OP_END = 4'h8
  } dps_op_t;
  typedef enum logic [1:0] {
    DPS_ST_IDLE = 2'h0, DPS_ST_RUN = 2'h1,
    DPS_ST_NOP = 2'h3, DPS_ST_ENDW = 2'h2
  } dps_state_t;
  typedef enum logic [2:0] {
    DPS_SRC_NONE = 3'h0, DPS_SRC_ALU = 3'h1, DPS_SRC_EXT16 = 3'h2,
    DPS_SRC_JCOND = 3'h3, DPS_SRC_PC = 3'h4
  } dps_src_t;
  typedef enum logic [1:0] {
    DPS_DST_NONE = 2'h0, DPS_DST_WORD = 2'h1,
    DPS_DST_UPPER = 2'h2, DPS_DST_LOWER = 2'h3
  } dps_dst_t;
  // Operations issued together by one word
  typedef struct packed {
    logic mul;
    logic add;
    logic sub;
    logic xfer;
  } dps_issue_t;
  // Arithmetic unit condition flags
  typedef struct packed {
    logic sign_flag;
    logic overflow_flag;
    logic zero_flag;
  } dps_flags_t;
endpackage : dps_pkg
`default_nettype wire

//--- hw/dps_sequencer.sv
// Program sequencer: program RAM, program counter, stack, loop and
// data-bus routing, with an AXI4-Lite register slave.
// Assumes flags and data inputs come from logic on aclk; the frame clock
// and jump-condition pins are asynchronous and are synchronised here.
//
// Notes on behaviour
// - 384x32 program RAM, loaded while held idle
// - 5-bit loop count, condition reg, 24-bit path
// - 9-bit counter, one-entry stack holds return
// - One word issues multiply, add/sub, transfer together
// - Every sequence command is one word
// - Jump inserts exactly one idle cycle
// - Taken flag jump loads target, one idle
// - Failed flag jump continues without idle
// - Condition match jumps with idle, else continues
// - Capture pin condition at frame rise, always
// - Call pushes next address, one idle cycle
// - Return resumes at stacked address, no idle
// - Literal load puts 24-bit constant on bus
// - Count steps per frame against 574 budget
// - Narrow sources left-aligned, zero filled low
// - Destinations take bus MSBs; lower store LSBs
// - Bus zero for no source or reset
// - End idles until next frame rising edge
// - Loop repeats range, no idle on wrap
`default_nettype none
module dps_sequencer
  import dps_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int MAX_STEPS = FRAME_STEPS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_clock,
  input wire logic [COND_W-1:0] ext_jump_cond,
  input wire dps_flags_t alu_flags,
  input wire logic [DATA_W-1:0] alu_result,
  input wire logic [15:0] ext_data16,
  output logic [PC_W-1:0] program_counter,
  output logic [DATA_W-1:0] internal_data_bus,
  output dps_issue_t issue,
  output logic [DATA_W-1:0] dest_word,
  output logic [15:0] dest_upper,
  output logic [7:0] lower_byte_store
);
  if (ADDR_W < 8 || MAX_STEPS < 1 || MAX_STEPS >= (1 << STEP_W)) begin : g_chk
    $error("dps_sequencer: unsupported parameter value");
  end

  function automatic logic [31:0] dps_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : dps_merge

  logic [WORD_W-1:0] program_ram [PROGRAM_RAM_WORDS];
  logic run;
  logic [COND_W-1:0] external_condition_register;
  logic [PC_W-1:0] program_ram_addr;
  logic [COND_W-1:0] jump_condition;
  dps_state_t st;
  logic [PC_W-1:0] stack, loop_end;
  logic [LOOP_W-1:0] loop_cnt;
  logic loop_active;
  logic [STEP_W-1:0] steps_now, steps_last;
  logic overrun;
  logic frame_s1, frame_s2, frame_s3;
  logic [COND_W-1:0] cond_s1, cond_s2;
  logic aw_got, w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the second stage feeds logic, the third stage only detects the frame edge
  always_ff @(posedge aclk) begin
    frame_s1 <= frame_clock;
    frame_s2 <= frame_s1;
    frame_s3 <= frame_s2;
    cond_s1 <= ext_jump_cond;
    cond_s2 <= cond_s1;
  end
  logic frame_rise;
  assign frame_rise = frame_s2 && !frame_s3;

  // Condition capture also runs in reset, so the first frame sees it
  always_ff @(posedge aclk) begin
    if (frame_rise) begin
      jump_condition <= cond_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  logic [WORD_W-1:0] instr;
  dps_op_t op;
  logic [PC_W-1:0] target, pc_inc;
  logic in_run, cond_ok, jx_ok, take_jump, plain, loop_wrap;
  assign instr = (program_counter < PC_W'(PROGRAM_RAM_WORDS)) ?
      program_ram[program_counter] : '0;
  assign op = dps_op_t'(instr[OPC_LSB +: 4]);
  assign target = instr[TGT_LSB +: PC_W];
  assign pc_inc = program_counter + 9'h001;
  assign in_run = (st == DPS_ST_RUN);
  assign cond_ok = |(instr[CMASK_LSB +: 3] & alu_flags);
  assign jx_ok = |(jump_condition & external_condition_register);
  assign take_jump = in_run && (op == DPS_OP_JMP || op == DPS_OP_CALL ||
      (op == DPS_OP_JC && cond_ok) || (op == DPS_OP_JX && jx_ok));
  assign plain = (op == DPS_OP_EXEC || op == DPS_OP_LD);
  assign loop_wrap = in_run && plain && loop_active &&
      program_counter == loop_end && loop_cnt != 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; clearing run holds the core idle like a device reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      st <= DPS_ST_IDLE;
      program_counter <= PC_RESET;
      stack <= PC_RESET;
      loop_end <= PC_RESET;
      loop_cnt <= 5'h00;
      loop_active <= 1'b0;
    end else begin
      case (st)
        DPS_ST_IDLE: begin
          if (frame_rise) begin
            st <= DPS_ST_RUN;
          end
        end
        DPS_ST_NOP: begin
          st <= DPS_ST_RUN;
        end
        DPS_ST_ENDW: begin
          if (frame_rise) begin
            st <= DPS_ST_RUN;
            program_counter <= PC_RESET;
            loop_active <= 1'b0;
          end
        end
        DPS_ST_RUN: begin
          if (take_jump) begin
            program_counter <= target;
            st <= DPS_ST_NOP;
            if (op == DPS_OP_CALL) begin
              stack <= pc_inc;
            end
          end else if (op == DPS_OP_RET) begin
            program_counter <= stack;
          end else if (op == DPS_OP_END) begin
            st <= DPS_ST_ENDW;
          end else if (op == DPS_OP_LOOP) begin
            // Loop start shares the single stack entry with calls
            stack <= pc_inc;
            loop_end <= target;
            loop_cnt <= (instr[LCNT_LSB +: LOOP_W] == 5'h00) ? 5'h00 :
                instr[LCNT_LSB +: LOOP_W] - 5'h01;
            loop_active <= 1'b1;
            program_counter <= pc_inc;
          end else if (loop_wrap) begin
            program_counter <= stack;
            loop_cnt <= loop_cnt - 5'h01;
          end else begin
            program_counter <= pc_inc;
            if (plain && program_counter == loop_end) begin
              loop_active <= 1'b0;
            end
          end
        end
        default: st <= DPS_ST_IDLE;
      endcase
    end
  end

  // Steps per frame; overrun flags a program longer than the budget
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      steps_now <= 10'h000;
      steps_last <= 10'h000;
      overrun <= 1'b0;
    end else if (frame_rise) begin
      steps_last <= steps_now;
      steps_now <= 10'h000;
    end else if (in_run && steps_now != 10'h3FF) begin
      steps_now <= steps_now + 10'h001;
      if (steps_now >= STEP_W'(MAX_STEPS)) begin
        overrun <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data bus: narrow sources left-aligned, registered once
  logic [DATA_W-1:0] next_bus;
  dps_dst_t dst;
  always_comb begin
    next_bus = '0;
    dst = DPS_DST_NONE;
    if (in_run && op == DPS_OP_LD) begin
      next_bus = instr[DATA_W-1:0];
      dst = dps_dst_t'(instr[LDST_LSB +: 2]);
    end else if (in_run && op == DPS_OP_EXEC) begin
      dst = dps_dst_t'(instr[DST_LSB +: 2]);
      case (dps_src_t'(instr[SRC_LSB +: 3]))
        DPS_SRC_ALU: next_bus = alu_result;
        DPS_SRC_EXT16: next_bus = {ext_data16, 8'h00};
        DPS_SRC_JCOND: next_bus = {jump_condition, 16'h0000};
        DPS_SRC_PC: next_bus = {program_counter, 15'h0000};
        default: next_bus = '0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_data_bus <= '0;
      dest_word <= '0;
      dest_upper <= 16'h0000;
      lower_byte_store <= 8'h00;
    end else begin
      internal_data_bus <= next_bus;
      case (dst)
        DPS_DST_WORD: dest_word <= next_bus;
        DPS_DST_UPPER: dest_upper <= next_bus[23:8];
        DPS_DST_LOWER: lower_byte_store <= next_bus[7:0];
        default: ;
      endcase
    end
  end

  // Parallel issue of arithmetic and transfer from one word
  always_ff @(posedge aclk) begin
    if (!aresetn || !(in_run && op == DPS_OP_EXEC)) begin
      issue <= '0;
    end else begin
      issue.mul <= instr[MUL_BIT];
      issue.add <= instr[ADD_BIT];
      issue.sub <= instr[SUB_BIT];
      issue.xfer <= instr[SRC_LSB +: 3] != 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data in either order
  logic wr_fire, wr_bad;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign wr_bad = !(aw_addr == REG_CTRL || aw_addr == REG_EXT_COND ||
      aw_addr == REG_PROGRAM_RAM_ADDR || (aw_addr == REG_PROGRAM_RAM_DATA && !run));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control registers; software steers run and the condition mask
  logic [31:0] ctrl_new, cond_new, addr_new;
  assign ctrl_new = dps_merge({31'h0, run}, w_data, w_strb);
  assign cond_new = dps_merge({24'h0, external_condition_register},
      w_data, w_strb);
  assign addr_new = dps_merge({23'h0, program_ram_addr}, w_data, w_strb);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'b0;
      external_condition_register <= EXT_COND_RESET;
      program_ram_addr <= PC_RESET;
    end else if (wr_fire) begin
      case (aw_addr)
        REG_CTRL: run <= ctrl_new[0];
        REG_EXT_COND: external_condition_register <= cond_new[7:0];
        REG_PROGRAM_RAM_ADDR: program_ram_addr <= addr_new[PC_W-1:0];
        REG_PROGRAM_RAM_DATA: begin
          if (!run) begin
            program_ram_addr <= program_ram_addr + 9'h001;
          end
        end
        default: ;
      endcase
    end
  end

  // Program loading only while the core is held idle
  always_ff @(posedge aclk) begin
    if (wr_fire && aw_addr == REG_PROGRAM_RAM_DATA && !run &&
        program_ram_addr < PC_W'(PROGRAM_RAM_WORDS)) begin
      program_ram[program_ram_addr] <= dps_merge(program_ram[program_ram_addr],
          w_data, w_strb);
    end
  end

  // AXI4-Lite read side: data one cycle after the address is taken
  logic [31:0] rd_mux;
  logic rd_bad;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_bad = 1'b0;
    case (s_axi_araddr[7:0])
      REG_CTRL: rd_mux = {31'h0, run};
      REG_EXT_COND: rd_mux = {24'h0, external_condition_register};
      REG_PROGRAM_RAM_ADDR: rd_mux = {23'h0, program_ram_addr};
      REG_PROGRAM_RAM_DATA: rd_mux = (program_ram_addr < PC_W'(PROGRAM_RAM_WORDS)) ?
          program_ram[program_ram_addr] : 32'h0000_0000;
      REG_STATUS: rd_mux = {8'h00, jump_condition, 2'h0, st, 3'h0,
          program_counter};
      REG_STEPS: rd_mux = {overrun, 21'h0, steps_last};
      default: rd_bad = 1'b1;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !run);

  sequence s_one_idle;
    st == DPS_ST_NOP ##1 st == DPS_ST_RUN;
  endsequence

  AST_JUMP_ONE_NOP: assert property (
    in_run && op == DPS_OP_JMP |=> s_one_idle)
    else $error("jump did not insert one idle cycle");
  AST_JUMP_TARGET: assert property (
    in_run && op == DPS_OP_JC && cond_ok |=>
      program_counter == $past(target) ##0 s_one_idle)
    else $error("taken flag jump went wrong");
  AST_COND_FAIL: assert property (
    in_run && op == DPS_OP_JC && !cond_ok && !loop_wrap |=>
      in_run && program_counter == $past(pc_inc))
    else $error("failed flag jump stalled or strayed");
  AST_JX_MATCH: assert property (
    in_run && op == DPS_OP_JX |=> (st == DPS_ST_NOP) ==
      $past(|(jump_condition & external_condition_register)))
    else $error("condition jump decision wrong");
  AST_CALL_PUSH: assert property (
    in_run && op == DPS_OP_CALL |=> stack == $past(pc_inc) ##0 s_one_idle)
    else $error("call did not push next address");
  AST_RETURN: assert property (
    in_run && op == DPS_OP_RET |=> in_run &&
      program_counter == $past(stack))
    else $error("return did not resume at stack");
  AST_END_HOLD: assert property (
    st == DPS_ST_ENDW && !frame_rise |=> st == DPS_ST_ENDW)
    else $error("end left before frame edge");
  AST_LOOP_WRAP: assert property (
    loop_wrap |=> in_run && program_counter == $past(stack))
    else $error("loop wrap missed or idled");
  AST_DEST_MSB: assert property (
    in_run && op == DPS_OP_EXEC && dst == DPS_DST_UPPER |=>
      dest_upper == internal_data_bus[23:8])
    else $error("upper store not from bus MSBs");
  AST_BUS_NONE: assert property (
    in_run && op == DPS_OP_EXEC && instr[SRC_LSB +: 3] == 3'h0 |=>
      internal_data_bus == '0)
    else $error("bus not zero without source");
  AST_JC_CAPTURE: assert property (disable iff (1'b0)
    frame_rise |=> jump_condition == $past(cond_s2))
    else $error("condition not captured at frame edge");
  AST_RESET_PC: assert property (disable iff (1'b0)
    !aresetn |=> program_counter == PC_RESET && st == DPS_ST_IDLE &&
      internal_data_bus == '0)
    else $error("reset did not clear sequencer");
endmodule : dps_sequencer
`default_nettype wire
